/* File: verif/apd_axis_checker.sv */
/* checker for apd_axis: calibration level, emergency stop, readback.
   assumes a zero-wait apb slave and the bits of apd_params.svh. */
`timescale 1ns/1ps
`include "apd_params.svh"
module apd_axis_checker
  import apd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire apd_enc_s    enc_in,
  input wire logic [15:0] dac_code
);
  logic        wr_e, rd_e, cal_m, emrg_m, rev_m, pos_ok;
  logic [31:0] vout_m, ofs_m, pos_m;
  logic [2:0]  q_r, e_r;
  logic [15:0] exp_c;
  apd_enc_s    enc_q;
  assign wr_e = psel && penable && pready && pwrite;
  assign rd_e = psel && penable && pready && !pwrite;
  function automatic logic [15:0] sat(int v, int o);
    int t;
    t = v * 32767 / 100 + o;
    return (t > 32767) ? 16'h7fff : (t < -32768) ? 16'h8000 : t[15:0];
  endfunction : sat
  assign exp_c = sat(vout_m, ofs_m);
  // command flag mirrors
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cal_m  <= 1'b0;
      emrg_m <= 1'b1;
      rev_m  <= 1'b0;
    end
    else if (wr_e && paddr == `APD_OFS_CMD)
    begin
      if (pwdata[`APD_CMD_CAL_ON]) cal_m <= 1'b1;
      else if (pwdata[`APD_CMD_CAL_OFF]) cal_m <= 1'b0;
      if (pwdata[`APD_CMD_EMRG]) emrg_m <= 1'b1;
      else if (pwdata[`APD_CMD_RESUME]) emrg_m <= 1'b0;
      if (pwdata[`APD_CMD_CNTREV]) rev_m <= !rev_m;
    end
  // register mirrors; position valid while phases stand still
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      vout_m <= '0;
      ofs_m  <= '0;
      pos_m  <= '0;
      pos_ok <= 1'b0;
      enc_q  <= '0;
    end
    else
    begin
      enc_q <= enc_in;
      if (wr_e && paddr == `APD_OFS_VOUT) vout_m <= pwdata;
      if (wr_e && paddr == `APD_OFS_OFFSET) ofs_m <= pwdata;
      if (wr_e && paddr == `APD_OFS_POSIT) pos_m <= pwdata;
      pos_ok <= (wr_e && paddr == `APD_OFS_POSIT) || (pos_ok && enc_in == enc_q);
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      q_r <= '0;
      e_r <= '0;
    end
    else
    begin
      q_r <= wr_e ? 3'h0 : (q_r == 3'h7) ? q_r : q_r + 3'h1;
      e_r <= !(emrg_m && !cal_m) ? 3'h0 : (e_r == 3'h7) ? e_r : e_r + 3'h1;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_emrg_wr;
    wr_e && paddr == `APD_OFS_CMD && pwdata[`APD_CMD_EMRG];
  endsequence
  sequence s_vout_wr;
    wr_e && paddr == `APD_OFS_VOUT && cal_m && !emrg_m;
  endsequence
  a_emrg_zero: assert property (s_emrg_wr |-> ##3 dac_code == 16'h0)
    else $error("dac not zero after emergency");
  a_emrg_hold: assert property (e_r == 3'h7 |-> dac_code == 16'h0)
    else $error("dac not held at zero");
  a_cal_level: assert property (cal_m && !emrg_m && q_r == 3'h7 |-> dac_code == exp_c)
    else $error("calibration level wrong");
  a_cal_step: assert property (s_vout_wr ##1 (!wr_e) [*2] |=> dac_code == exp_c)
    else $error("calibration step late");
  a_status_flags: assert property (rd_e && paddr == `APD_OFS_STATUS |-> prdata[1:0] == {emrg_m, cal_m})
    else $error("status flags wrong");
  a_rev_status: assert property (rd_e && paddr == `APD_OFS_STATUS |-> prdata[4] == rev_m)
    else $error("reverse flag wrong");
  a_dac_readback: assert property (rd_e && paddr == `APD_OFS_DACOUT |-> prdata == {{16{dac_code[15]}}, dac_code})
    else $error("dac readback wrong");
  a_pos_load: assert property (rd_e && paddr == `APD_OFS_POSIT && pos_ok |-> prdata == pos_m)
    else $error("position load lost");
endmodule : apd_axis_checker
bind apd_axis apd_axis_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .enc_in, .dac_code);

/* File: verif/apd_drive_model.sv */
/* behavioural servo drive: speed code in, quadrature phases out.
   assumes a signed 16-bit speed code, full scale either way. */
`timescale 1ns/1ps
module apd_drive_model
  import apd_pkg::*;
(
  input  wire logic [15:0] dac_code,
  input  wire logic        pclk,
  input  wire logic        presetn,
  output      apd_enc_s    enc
);
  int         acc;
  logic [1:0] ph;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      acc <= 0;
      ph  <= 2'h0;
    end
    else if (acc >= 65536)
    begin
      acc <= acc - 65536 + $signed(dac_code);
      ph  <= ph + 2'h1;
    end
    else if (acc <= -65536)
    begin
      acc <= acc + 65536 + $signed(dac_code);
      ph  <= ph - 2'h1;
    end
    else
      acc <= acc + $signed(dac_code);
  assign enc = {ph[1], ph[1] ^ ph[0]};
endmodule : apd_drive_model

/* File: verif/test_apd_axis.sv */
/* bench for apd_axis: registers, calibration, encoder, emergency.
   assumes the drive model closes the loop at the far side. */
`timescale 1ns/1ps
`include "apd_params.svh"
module test_apd_axis
  import apd_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, last_rd, seed, d1, d2, vm;
  logic [15:0] dac_code;
  logic [63:0] q[$];
  logic [63:0] n;
  apd_enc_s    enc;
  int          miscompares, n_checks;
  always #50 pclk = !pclk;
  apd_axis #(.SAMPLE_CYC(16), .SEC_CYC(64), .CS_CYC(8)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_in(enc), .dac_code);
  apd_drive_model drv (.pclk, .presetn, .dac_code, .enc);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] dexp(int v, int o);
    int t;
    t = v * 32767 / 100 + o;
    return (t > 32767) ? 32767 : (t < -32768) ? -32768 : t;
  endfunction : dexp
  function automatic int mag(int x);
    return x < 0 ? -x : x;
  endfunction : mag
  task automatic check(logic [31:0] seen, logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m = 32'hffff_ffff);
    q.push_back({m, e & m});
    apb(1'b0, a, 32'h0);
    @(negedge pclk);
  endtask : rd
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic cmd(int b);
    wr(`APD_OFS_CMD, 32'h1 << b);
  endtask : cmd
  task automatic cal(int v, int o);
    wr(`APD_OFS_VOUT, v);
    wr(`APD_OFS_OFFSET, o);
    repeat (4) @(posedge pclk);
    rd(`APD_OFS_DACOUT, dexp(v, o));
  endtask : cal
  task automatic span(output logic [31:0] d);
    logic [31:0] p;
    rd(`APD_OFS_POSIT, 0, 0);
    p = last_rd;
    repeat (200) @(posedge pclk);
    rd(`APD_OFS_POSIT, 0, 0);
    d = last_rd - p;
  endtask : span
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // result monitor: oldest note against each read
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      n = q.pop_front();
      last_rd = prdata;
      check(prdata & n[63:32], n[31:0]);
      check({31'h0, pslverr}, 32'h0);
    end
  initial
  begin
    repeat (6000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    miscompares = 0;
    n_checks = 0;
    seed = 32'h0001_1cf8;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`APD_OFS_STATUS, 32'h2, 32'h1f);
    rd(`APD_OFS_FEEDFW, `APD_RST_FEEDFW);
    rd(`APD_OFS_TACC, `APD_RST_TACC);
    rd(`APD_OFS_MAXVEL, `APD_RST_MAXVEL);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    $display("test reset done");
    cmd(`APD_CMD_RESUME);
    cmd(`APD_CMD_CAL_ON);
    rd(`APD_OFS_STATUS, 32'h1, 32'h3);
    cal(0, 0);
    cal(100, 7);
    cal(-100, -5);
    cal(5, 0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      cal(-20 + 10 * i, $signed(seed[9:0]));
    end
    cal(50, 0);
    span(d1);
    rd(`APD_OFS_FRQ, 0, 0);
    check(last_rd != 0, 1'b1);
    rd(`APD_OFS_VEL, 0, 0);
    vm = last_rd;
    wr(`APD_OFS_UNITVEL, 32'h1);
    repeat (140) @(posedge pclk);
    rd(`APD_OFS_VEL, 0, 0);
    check(last_rd != 0 && mag(vm) > mag(last_rd), 1'b1);
    cmd(`APD_CMD_CNTREV);
    rd(`APD_OFS_STATUS, 32'h10, 32'h10);
    span(d2);
    check(d1 != 0 && d2 != 0 && d1[31] != d2[31], 1'b1);
    cmd(`APD_CMD_CAL_OFF);
    rd(`APD_OFS_STATUS, 32'h0, 32'h1);
    $display("test calibration and encoder done");
    wr(`APD_OFS_MAXPOS, 32'h4000);
    wr(`APD_OFS_SETVEL, 32'h8);
    wr(`APD_OFS_SETPOS, 32'h2000);
    cmd(`APD_CMD_LOOPON);
    rd(`APD_OFS_STATUS, 32'h4, 32'h4);
    cmd(`APD_CMD_START);
    repeat (40) @(posedge pclk);
    rd(`APD_OFS_STATUS, 32'h8, 32'ha);
    check(dac_code != 16'h0, 1'b1);
    cmd(`APD_CMD_EMRG);
    repeat (10) @(posedge pclk);
    rd(`APD_OFS_STATUS, 32'h2, 32'ha);
    rd(`APD_OFS_DACOUT, 32'h0);
    cmd(`APD_CMD_START);
    rd(`APD_OFS_STATUS, 32'h2, 32'ha);
    seed = lfsr(seed);
    wr(`APD_OFS_POSIT, seed);
    rd(`APD_OFS_POSIT, seed);
    wr(`APD_OFS_PGAIN, 32'h3e8);
    cmd(`APD_CMD_RESUME);
    wr(`APD_OFS_POSIT, seed + 32'h64);
    repeat (20) @(negedge pclk);
    check({31'h0, dac_code[15]}, 32'h1);
    $display("test move and emergency done");
    stop_test();
  end
endmodule : test_apd_axis

/* File: verilog/apd_axis.sv */
/*
  single-axis pid+ff position loop with apb register access, quadrature
  encoder input and 16-bit signed speed reference output.
  assumes encoder phases are asynchronous pins and the dac converts the
  code to plus/minus 10 V outside this block.
*/
`timescale 1ns/1ps
`include "apd_params.svh"
module apd_axis
  import apd_pkg::*;
#(
  parameter int SAMPLE_CYC = `APD_SAMPLE_CYC,
  parameter int SEC_CYC    = `APD_SEC_CYC,
  parameter int CS_CYC     = `APD_CS_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire apd_enc_s    enc_in,
  output      logic [15:0] dac_code
);

  // refuse timings that the tick and window counters cannot serve
  if (SAMPLE_CYC < 2 || SEC_CYC < SAMPLE_CYC || CS_CYC < 1)
  begin : g_bad_timing
    $error("apd_axis: bad timing parameters");
  end

  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sd32767)
      sat16 = 16'sh7fff;
    else if (v < -48'sd32768)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction : sat16

  function automatic logic signed [47:0] sx32(input logic [31:0] v);
    sx32 = {{16{v[31]}}, v};
  endfunction : sx32

  // divisor guard, a zero setting divides by one
  function automatic logic [31:0] nz32(input logic [31:0] v);
    nz32 = (v == 32'h0) ? 32'h1 : v;
  endfunction : nz32

  // registers
  logic signed [31:0] vout_r;
  logic signed [31:0] offset_r;
  logic signed [31:0] minpos_r;
  logic signed [31:0] maxpos_r;
  logic signed [31:0] setpos_r;
  logic signed [31:0] posit_r;
  logic        [31:0] maxvel_r;
  logic        [31:0] tacc_r;
  logic        [31:0] setvel_r;
  logic        [31:0] feedfw_r;
  logic        [31:0] pgain_r;
  logic        [31:0] integt_r;
  logic        [31:0] derivt_r;
  logic               unitvel_r;
  logic        [31:0] frq_r;
  logic        [31:0] vel_r;
  apd_status_s        st_r;
  apd_move_e          mv_r;

  wire wr_en = psel && penable && pwrite;
  wire cmd_wr = wr_en && (paddr == `APD_OFS_CMD);
  wire [7:0] cmd = cmd_wr ? pwdata[7:0] : 8'h00;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // encoder synchronisers
  logic [1:0] a_s;
  logic [1:0] b_s;
  logic       a_q;
  logic       b_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_s <= 2'b00;
      b_s <= 2'b00;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      a_s <= {a_s[0], enc_in.enc_a};
      b_s <= {b_s[0], enc_in.enc_b};
      a_q <= a_s[1];
      b_q <= b_s[1];
    end
  end

  // x4 quadrature decode
  wire step  = (a_s[1] ^ a_q) | (b_s[1] ^ b_q);
  wire fwd   = a_s[1] ^ b_q;
  wire up    = fwd ^ st_r.cntrev;
  wire a_edge = a_s[1] & ~a_q;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vout_r    <= 32'sh0;
      offset_r  <= 32'sh0;
      maxvel_r  <= `APD_RST_MAXVEL;
      unitvel_r <= 1'b0;
      minpos_r  <= 32'sh0;
      maxpos_r  <= 32'sh0;
      tacc_r    <= `APD_RST_TACC;
      setvel_r  <= 32'h0;
      setpos_r  <= 32'sh0;
      feedfw_r  <= `APD_RST_FEEDFW;
      pgain_r   <= 32'h0;
      integt_r  <= 32'h0;
      derivt_r  <= 32'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `APD_OFS_VOUT:    vout_r    <= pwdata;
        `APD_OFS_OFFSET:  offset_r  <= pwdata;
        `APD_OFS_MAXVEL:  maxvel_r  <= pwdata;
        `APD_OFS_UNITVEL: unitvel_r <= pwdata[0];
        `APD_OFS_MINPOS:  minpos_r  <= pwdata;
        `APD_OFS_MAXPOS:  maxpos_r  <= pwdata;
        `APD_OFS_TACC:    tacc_r    <= pwdata;
        `APD_OFS_SETVEL:  setvel_r  <= pwdata;
        `APD_OFS_SETPOS:  setpos_r  <= pwdata;
        `APD_OFS_FEEDFW:  feedfw_r  <= pwdata;
        `APD_OFS_PGAIN:   pgain_r   <= pwdata;
        `APD_OFS_INTEGT:  integt_r  <= pwdata;
        `APD_OFS_DERIVT:  derivt_r  <= pwdata;
        default: ;
      endcase
    end
  end

  // position counter, software load wins over a count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      posit_r <= 32'sh0;
    else if (wr_en && paddr == `APD_OFS_POSIT)
      posit_r <= pwdata;
    else if (step)
      posit_r <= up ? posit_r + 32'sd1 : posit_r - 32'sd1;
  end

  // status flags, moving lags the profile state by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r.calib_active_flag <= 1'b0;
      st_r.emergency_flag    <= 1'b1;
      st_r.loopon            <= 1'b0;
      st_r.moving            <= 1'b0;
      st_r.cntrev            <= 1'b0;
    end
    else
    begin
      st_r.moving <= (mv_r != APD_IDLE);
      if (cmd[`APD_CMD_CAL_ON])
        st_r.calib_active_flag <= 1'b1;
      else if (cmd[`APD_CMD_CAL_OFF])
        st_r.calib_active_flag <= 1'b0;
      if (cmd[`APD_CMD_EMRG])
        st_r.emergency_flag <= 1'b1;
      else if (cmd[`APD_CMD_RESUME])
        st_r.emergency_flag <= 1'b0;
      if (cmd[`APD_CMD_LOOPON])
        st_r.loopon <= 1'b1;
      else if (cmd[`APD_CMD_LOOPOFF])
        st_r.loopon <= 1'b0;
      if (cmd[`APD_CMD_CNTREV])
        st_r.cntrev <= ~st_r.cntrev;
    end
  end

  // frequency and speed measure over one second window
  logic [31:0] sec_cnt, a_cnt, s_cnt;
  logic signed [31:0] pos_mark;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_cnt  <= 32'h0;
      a_cnt    <= 32'h0;
      frq_r    <= 32'h0;
      vel_r    <= 32'h0;
      pos_mark <= 32'sh0;
    end
    else if (sec_cnt == 32'(SEC_CYC - 1))
    begin
      sec_cnt  <= 32'h0;
      a_cnt    <= 32'h0;
      frq_r    <= a_cnt + {31'h0, a_edge};
      pos_mark <= posit_r;
      vel_r    <= unitvel_r ? 32'(posit_r - pos_mark)
                            : 32'((posit_r - pos_mark) * 32'sd60);
    end
    else
    begin
      sec_cnt <= sec_cnt + 32'h1;
      if (a_edge)
        a_cnt <= a_cnt + 32'h1;
    end
  end

  // sampling tick and profile
  logic [31:0] smp_cnt, cs_cnt;
  logic signed [31:0] ref_pos, ref_vel, err_prev;
  logic signed [47:0] integ_acc;
  logic signed [15:0] out_r;
  wire tick = (smp_cnt == 32'(SAMPLE_CYC - 1));
  wire signed [31:0] tgt = (setpos_r < minpos_r) ? minpos_r :
                           (setpos_r > maxpos_r) ? maxpos_r : setpos_r;
  wire signed [31:0] err = ref_pos - posit_r;
  // per-tick velocity step so that tacc reaches maxvel (units per sample scale)
  wire signed [31:0] acc_step = (tacc_r == 32'h0) ? $signed(maxvel_r)
                              : $signed(32'((64'(maxvel_r) * 64'(SAMPLE_CYC)) /
                                            (64'(tacc_r) * 64'(CS_CYC)) + 64'h1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      smp_cnt <= 32'h0;
    else
      smp_cnt <= tick ? 32'h0 : smp_cnt + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mv_r    <= APD_IDLE;
      ref_pos <= 32'sh0;
      ref_vel <= 32'sh0;
    end
    // emergency drops the move at once, no ramp
    else if (st_r.emergency_flag || cmd[`APD_CMD_EMRG])
    begin
      mv_r    <= APD_IDLE;
      ref_vel <= 32'sh0;
      ref_pos <= posit_r;
    end
    else
    begin
      case (mv_r)
        APD_IDLE:
        begin
          ref_vel <= 32'sh0;
          if (cmd[`APD_CMD_START] && !st_r.calib_active_flag)
          begin
            mv_r    <= APD_ACCEL;
            ref_pos <= posit_r;
          end
          else if (!st_r.loopon)
            ref_pos <= posit_r;
        end
        APD_ACCEL, APD_CRUISE:
          if (tick)
          begin
            if (ref_pos == tgt)
            begin
              mv_r    <= APD_DONE;
              ref_vel <= 32'sh0;
            end
            else
            begin
              if (ref_vel < $signed(setvel_r))
                ref_vel <= (ref_vel + acc_step > $signed(setvel_r)) ? $signed(setvel_r)
                                                                    : ref_vel + acc_step;
              else
                mv_r <= APD_CRUISE;
              // steps in position units per sample, clipped at target
              if (tgt > ref_pos)
                ref_pos <= (tgt - ref_pos > ref_vel) ? ref_pos + ref_vel : tgt;
              else
                ref_pos <= (ref_pos - tgt > ref_vel) ? ref_pos - ref_vel : tgt;
            end
          end
        APD_DONE:
          mv_r <= APD_IDLE;
        default:
          mv_r <= APD_IDLE;
      endcase
    end
  end

  // pid+ff law, evaluated once per sample
  wire closed = st_r.loopon && !st_r.emergency_flag;
  wire signed [47:0] ff_t = (sx32(ref_vel) * sx32(feedfw_r) * 48'sd32767) /
                            (sx32(nz32(maxvel_r)) * 48'sd1000);
  wire signed [47:0] p_t = (sx32(err) * sx32(pgain_r) * 48'sd32767) /
                           (sx32(nz32(maxvel_r)) * 48'sd1000);
  wire signed [47:0] i_t = integ_acc / sx32(nz32(integt_r));
  wire signed [47:0] d_t = (sx32(err - err_prev) * sx32(derivt_r));
  wire signed [47:0] cal_t = (sx32(vout_r) * 48'sd32767) / 48'sd100;
  wire signed [47:0] loop_t = closed ? ff_t + p_t + (integt_r != 32'h0 ? i_t : 48'sh0) + d_t
                                     : ff_t;
  wire signed [47:0] sum = st_r.emergency_flag ? 48'sh0
                         : (st_r.calib_active_flag ? cal_t : loop_t) + sx32(offset_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      integ_acc <= 48'sh0;
      err_prev  <= 32'sh0;
    end
    else if (!closed || err == 32'sh0)
    begin
      integ_acc <= 48'sh0;
      err_prev  <= err;
    end
    else if (tick)
    begin
      integ_acc <= integ_acc + sx32(err);
      err_prev  <= err;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_r <= 16'sh0;
    else if (st_r.emergency_flag)
      out_r <= 16'sh0;
    else if (tick || st_r.calib_active_flag)
      out_r <= sat16(sum);
  end
  assign dac_code = out_r;

  // apb read mux
  always_comb
  begin
    case (paddr)
      `APD_OFS_STATUS:  prdata = {27'h0, st_r};
      `APD_OFS_VOUT:    prdata = vout_r;
      `APD_OFS_OFFSET:  prdata = offset_r;
      `APD_OFS_MAXVEL:  prdata = maxvel_r;
      `APD_OFS_UNITVEL: prdata = {31'h0, unitvel_r};
      `APD_OFS_POSIT:   prdata = posit_r;
      `APD_OFS_MINPOS:  prdata = minpos_r;
      `APD_OFS_MAXPOS:  prdata = maxpos_r;
      `APD_OFS_TACC:    prdata = tacc_r;
      `APD_OFS_SETVEL:  prdata = setvel_r;
      `APD_OFS_SETPOS:  prdata = setpos_r;
      `APD_OFS_FEEDFW:  prdata = feedfw_r;
      `APD_OFS_PGAIN:   prdata = pgain_r;
      `APD_OFS_INTEGT:  prdata = integt_r;
      `APD_OFS_DERIVT:  prdata = derivt_r;
      `APD_OFS_FRQ:     prdata = frq_r;
      `APD_OFS_VEL:     prdata = vel_r;
      `APD_OFS_DACOUT:  prdata = {{16{out_r[15]}}, out_r};
      default:          prdata = 32'h0;
    endcase
  end

endmodule : apd_axis

/* File: verilog/apd_params.svh */
/*
  constants for the single-axis position loop: register offsets, reset
  values, scaling figures and timing counts.
  assumes a 10 MHz pclk and an apb master with 32-bit data.
*/
// Notes on behaviour
// - speed reference is a signed 16-bit code spanning plus/minus ten volts.
// - enter-calibration sets the calibration flag and drives a constant output.
// - calibration voltage is in tenths of a volt, -100 to 100.
// - encoder phase frequency in hertz is readable while moving.
// - actual-position counter accumulates encoder counts, readable any time.
// - count-reverse command inverts the counting direction.
// - signed offset, 0.3 mV per step, added to output in every mode; the code leaves it out while the emergency flag zeroes the output.
// - leave-calibration clears the flag and stops the fixed voltage.
// - programmed maximum velocity maps linearly to full scale either polarity.
// - velocity-unit setting selects units per minute or per second.
// - actual speed is measured continuously and readable in selected units.
// - lower and upper travel limits bound positioning targets.
// - acceleration time in hundredths of a second, 100 means one second.
// - writing the position value loads the counter.
// - start begins a move to target at set velocity; emergency halts it.
// - closed-loop output is feed-forward plus proportional, integral, derivative.
// - feed-forward gain in thousandths of the profile speed.
// - proportional gain 1000 gives full scale at one-period max-speed error.
// - integral accumulates error over a programmable time until error is zero.
// - derivative acts on error change over a programmable time.
// - emergency sets its flag, stops without ramp, zeroes output, opens loop.
`ifndef APD_PARAMS_SVH
`define APD_PARAMS_SVH

`define APD_OFS_CMD      12'h000
`define APD_OFS_STATUS   12'h004
`define APD_OFS_VOUT     12'h008
`define APD_OFS_OFFSET   12'h00c
`define APD_OFS_MAXVEL   12'h010
`define APD_OFS_UNITVEL  12'h014
`define APD_OFS_POSIT    12'h018
`define APD_OFS_MINPOS   12'h01c
`define APD_OFS_MAXPOS   12'h020
`define APD_OFS_TACC     12'h024
`define APD_OFS_SETVEL   12'h028
`define APD_OFS_SETPOS   12'h02c
`define APD_OFS_FEEDFW   12'h030
`define APD_OFS_PGAIN    12'h034
`define APD_OFS_INTEGT   12'h038
`define APD_OFS_DERIVT   12'h03c
`define APD_OFS_FRQ      12'h040
`define APD_OFS_VEL      12'h044
`define APD_OFS_DACOUT   12'h048

// command register bits
`define APD_CMD_CAL_ON   0
`define APD_CMD_CAL_OFF  1
`define APD_CMD_CNTREV   2
`define APD_CMD_START    3
`define APD_CMD_EMRG     4
`define APD_CMD_RESUME   5
`define APD_CMD_LOOPON   6
`define APD_CMD_LOOPOFF  7
// status register bits
`define APD_CALIB_ACTIVE_FLAG       0
`define APD_EMERGENCY_FLAG      1
`define APD_ST_LOOPON    2
`define APD_ST_MOVING    3
`define APD_ST_CNTREV    4

`define APD_RST_FEEDFW   32'h0000_03e8
`define APD_RST_TACC     32'h0000_0064
`define APD_RST_MAXVEL   32'h0000_03e8
`define APD_VOUT_FULL    100
`define APD_DAC_FULL     32767
`define APD_GAIN_UNIT    1000
`define APD_CLK_HZ       10000000
`define APD_SAMPLE_US    1000
`define APD_SAMPLE_CYC   ((`APD_CLK_HZ / 1000000) * `APD_SAMPLE_US)
`define APD_CS_CYC       (`APD_CLK_HZ / 100)
`define APD_SEC_CYC      `APD_CLK_HZ

`endif

/* File: verilog/apd_pkg.sv */
/*
  types for the single-axis position loop.
  assumes apd_params.svh supplies the numeric constants.
*/
package apd_pkg;
  typedef enum logic [1:0] {
    APD_IDLE,
    APD_ACCEL,
    APD_CRUISE,
    APD_DONE
  } apd_move_e;

  typedef struct packed {
    logic cntrev;
    logic moving;
    logic loopon;
    logic emergency_flag;
    logic calib_active_flag;
  } apd_status_s;

  typedef struct packed {
    logic enc_a;
    logic enc_b;
  } apd_enc_s;
endpackage : apd_pkg
